// File: verilog/rfe_defines.vh
`ifndef RFE_DEFINES_VH
`define RFE_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define RFE_IDX_FRAME_SETUP 8'h18
`define RFE_IDX_CRC_SETUP 8'h19
`define RFE_IDX_CMD 8'h30
`define RFE_IDX_NUM_BYTES 8'h31
`define RFE_IDX_IRQ_STATUS 8'h32
`define RFE_IDX_IRQ_MASK 8'h33
`define RFE_IDX_STATE 8'h34

// ----------------------------------------------------------------------
// tx_frame_setup fields
// ----------------------------------------------------------------------
`define RFE_FS_FIRST_LO 0
`define RFE_FS_LAST_LO 3
`define RFE_FS_START_LO 6
`define RFE_FS_STOP_LO 8
`define RFE_FS_DATA_EN 10
`define RFE_FS_PAR_EN 11
`define RFE_FS_PAR_ODD 12
`define RFE_FS_PAR_LAST_INV 13
`define RFE_FS_WMASK 32'h00003FFF
`define RFE_FS_RESET 32'h00000000

// ----------------------------------------------------------------------
// tx_crc_setup fields
// ----------------------------------------------------------------------
`define RFE_CS_EN 0
`define RFE_CS_INV 1
`define RFE_CS_TYPE5 2
`define RFE_CS_SEL_LO 3
`define RFE_CS_SKIP1 6
`define RFE_CS_CUSTOM_LO 16
`define RFE_CS_WMASK 32'hFFFF007F
`define RFE_CS_RESET 32'h00000000

// ----------------------------------------------------------------------
// crc presets and polynomials (lsb-first, reflected)
// ----------------------------------------------------------------------
`define RFE_PRESET_0 16'h0000
`define RFE_PRESET_1 16'h6363
`define RFE_PRESET_2 16'hA671
`define RFE_PRESET_3 16'hFFFF
`define RFE_PRESET_4 16'h0012
`define RFE_PRESET_5 16'hE012
`define RFE_SEL_CUSTOM 3'h7
`define RFE_POLY16 16'h8408
`define RFE_POLY5 16'h0012
`define RFE_MASK5 16'h001F
`define RFE_LEN16 5'h10
`define RFE_LEN5 5'h05

// ----------------------------------------------------------------------
// command and interrupt bits
// ----------------------------------------------------------------------
`define RFE_CMD_START 0
`define RFE_IRQ_DONE 0
`define RFE_IRQ_NODATA 1
`define RFE_IRQ_W 2

`endif

// File: verilog/rfe_tx_encoder.v
// Contract
// - final data byte parity bit is inverted
// - parity type selects even or odd
// - parity bit appended after each byte
// - data on with zero count raises error
// - data enable gates the data section
// - stop field picks end symbol
// - start field picks opening symbol
// - last byte bit count drops trailing bits
// - first byte bit count drops leading bits
// - custom sixteen-bit preset held in upper half
// - skip control excludes first byte from crc
// - preset select picks fixed start value
// - five-bit crc uses preset low byte
// - code seven uses custom preset
// - crc type selects sixteen or five bits
// - invert control complements sent checksum
// - crc enable computes and sends checksum
`include "rfe_defines.vh"

module rfe_tx_encoder #(
  parameter ADDR_W = 12,
  parameter CNT_W = 16
) (
  input wire hclk, // bus clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [ADDR_W-1:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size, word only
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready in
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  output reg [31:0] hrdata, // read data
  output wire irq, // level interrupt
  input wire [7:0] in_data, // frame byte
  input wire in_valid, // byte offered
  output wire in_ready, // byte taken
  output wire out_valid, // element offered
  input wire out_ready, // element taken
  output wire out_is_sym, // element is a symbol
  output reg [1:0] out_sym, // symbol number
  output wire out_bit // data, parity or crc bit
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_LOAD = 7'h04;
  localparam [6:0] S_DBIT = 7'h08;
  localparam [6:0] S_PAR = 7'h10;
  localparam [6:0] S_CRC = 7'h20;
  localparam [6:0] S_STOP = 7'h40;
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  function [15:0] crc_preset;
    input [2:0] sel;
    input [15:0] custom;
    begin
      case (sel)
        3'h0: crc_preset = `RFE_PRESET_0;
        3'h1: crc_preset = `RFE_PRESET_1;
        3'h2: crc_preset = `RFE_PRESET_2;
        3'h3: crc_preset = `RFE_PRESET_3;
        3'h4: crc_preset = `RFE_PRESET_4;
        3'h5: crc_preset = `RFE_PRESET_5;
        `RFE_SEL_CUSTOM: crc_preset = custom;
        default: crc_preset = `RFE_PRESET_0;
      endcase
    end
  endfunction

  function [15:0] crc_step;
    input [15:0] c;
    input b;
    input t5;
    reg fb;
    begin
      fb = c[0] ^ b;
      if (t5) begin
        crc_step = ((c & `RFE_MASK5) >> 1) ^ (fb ? `RFE_POLY5 : 16'h0000);
      end else begin
        crc_step = (c >> 1) ^ (fb ? `RFE_POLY16 : 16'h0000);
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg [31:0] frame_setup_r;
  reg [31:0] crc_setup_r;
  reg [CNT_W-1:0] num_bytes_r;
  reg [`RFE_IRQ_W-1:0] irq_status_r;
  reg [`RFE_IRQ_W-1:0] irq_mask_r;
  reg start_r;
  reg ph_write_r;
  reg [7:0] ph_idx_r;

  reg [6:0] state_r;
  reg [15:0] sh_r;
  reg [15:0] crc_r;
  reg [4:0] cnt_r;
  reg [CNT_W-1:0] byte_idx_r;
  reg par_acc_r;
  reg done_r;
  reg nodata_r;

  // --------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------
  wire [2:0] first_bits = frame_setup_r[`RFE_FS_FIRST_LO +: 3];
  wire [2:0] last_bits = frame_setup_r[`RFE_FS_LAST_LO +: 3];
  wire [1:0] start_sym = frame_setup_r[`RFE_FS_START_LO +: 2];
  wire [1:0] stop_sym = frame_setup_r[`RFE_FS_STOP_LO +: 2];
  wire data_en = frame_setup_r[`RFE_FS_DATA_EN];
  wire par_en = frame_setup_r[`RFE_FS_PAR_EN];
  wire par_odd = frame_setup_r[`RFE_FS_PAR_ODD];
  wire par_last_inv = frame_setup_r[`RFE_FS_PAR_LAST_INV];
  wire crc_en = crc_setup_r[`RFE_CS_EN];
  wire crc_inv = crc_setup_r[`RFE_CS_INV];
  wire crc_t5 = crc_setup_r[`RFE_CS_TYPE5];
  wire [2:0] crc_sel = crc_setup_r[`RFE_CS_SEL_LO +: 3];
  wire crc_skip1 = crc_setup_r[`RFE_CS_SKIP1];
  wire [15:0] crc_custom = crc_setup_r[`RFE_CS_CUSTOM_LO +: 16];

  // --------------------------------------------------------------------
  // frame sequencing helpers
  // --------------------------------------------------------------------
  wire first_byte = (byte_idx_r == {CNT_W{1'b0}});
  wire last_byte = (byte_idx_r == num_bytes_r - CNT_ONE);
  wire [3:0] lo_bit = (first_byte && first_bits != 3'h0) ?
    (4'h8 - {1'b0, first_bits}) : 4'h0;
  wire [3:0] hi_bit = (last_byte && last_bits != 3'h0) ?
    {1'b0, last_bits} : 4'h8;
  wire [3:0] byte_len = (hi_bit > lo_bit) ? (hi_bit - lo_bit) : 4'h1;
  wire [15:0] preset = crc_preset(crc_sel, crc_custom);
  wire [15:0] crc_init = crc_t5 ?
    ({8'h00, preset[7:0]} & `RFE_MASK5) : preset;
  wire [4:0] crc_len = crc_t5 ? `RFE_LEN5 : `RFE_LEN16;
  wire crc_cover = ~(crc_skip1 & first_byte);
  wire [15:0] crc_nxt = crc_cover ?
    crc_step(crc_r, sh_r[0], crc_t5) : crc_r;
  // last bit of a byte without parity is folded in before sending
  wire [15:0] crc_fin = (state_r == S_DBIT) ? crc_nxt : crc_r;
  wire [15:0] crc_tx = (crc_fin ^ {16{crc_inv}}) &
    (crc_t5 ? `RFE_MASK5 : 16'hFFFF);
  wire par_next = par_acc_r ^ sh_r[0];
  wire par_bit = par_next ^ par_odd ^ (last_byte & par_last_inv);

  // --------------------------------------------------------------------
  // section order
  // --------------------------------------------------------------------
  wire [6:0] after_crc = (stop_sym != 2'h0) ? S_STOP : S_IDLE;
  wire [6:0] after_data = last_byte ?
    ((crc_en) ? S_CRC : after_crc) : S_LOAD;
  wire [6:0] after_start = data_en ? S_LOAD : after_crc;

  // --------------------------------------------------------------------
  // handshake events
  // --------------------------------------------------------------------
  wire take = out_valid & out_ready;
  wire byte_end = take & ((state_r == S_PAR) |
    ((state_r == S_DBIT) & (cnt_r == 5'h01) & ~par_en));
  wire frame_end = take & (((state_r == S_CRC) & (cnt_r == 5'h01) &
    (after_crc == S_IDLE)) | (state_r == S_STOP));

  // --------------------------------------------------------------------
  // byte and element handshake outputs
  // --------------------------------------------------------------------
  assign in_ready = (state_r == S_LOAD);
  assign out_valid = (state_r == S_START) | (state_r == S_DBIT) |
    (state_r == S_PAR) | (state_r == S_CRC) | (state_r == S_STOP);
  assign out_is_sym = state_r[1] | state_r[6];
  assign out_bit = sh_r[0];

  // --------------------------------------------------------------------
  // frame engine
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      sh_r <= 16'h0000;
      crc_r <= 16'h0000;
      cnt_r <= 5'h00;
      byte_idx_r <= {CNT_W{1'b0}};
      par_acc_r <= 1'b0;
      out_sym <= 2'h0;
      done_r <= 1'b0;
      nodata_r <= 1'b0;
    end else begin
      done_r <= frame_end;
      nodata_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start_r) begin
            if (data_en && num_bytes_r == {CNT_W{1'b0}}) begin
              nodata_r <= 1'b1;
            end else begin
              crc_r <= crc_init;
              byte_idx_r <= {CNT_W{1'b0}};
              if (start_sym != 2'h0) begin
                state_r <= S_START;
                out_sym <= start_sym - 2'h1;
              end else begin
                state_r <= after_start;
                out_sym <= stop_sym;
                if (after_start == S_IDLE) begin
                  done_r <= 1'b1;
                end
              end
            end
          end
        end
        S_START: begin
          if (take) begin
            state_r <= after_start;
            out_sym <= stop_sym;
            if (after_start == S_IDLE) begin
              done_r <= 1'b1;
            end
          end
        end
        S_LOAD: begin
          if (in_valid) begin
            sh_r <= {8'h00, in_data >> lo_bit};
            cnt_r <= {1'b0, byte_len};
            par_acc_r <= 1'b0;
            state_r <= S_DBIT;
          end
        end
        S_DBIT: begin
          if (take) begin
            crc_r <= crc_nxt;
            par_acc_r <= par_next;
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01 && par_en) begin
              sh_r <= {15'h0000, par_bit};
              state_r <= S_PAR;
            end else begin
              sh_r <= sh_r >> 1;
            end
          end
        end
        S_PAR: begin
          sh_r <= sh_r;
        end
        S_CRC: begin
          if (take) begin
            sh_r <= sh_r >> 1;
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              state_r <= after_crc;
            end
          end
        end
        S_STOP: begin
          if (take) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      if (byte_end) begin
        byte_idx_r <= byte_idx_r + CNT_ONE;
        state_r <= after_data;
        if (after_data == S_CRC) begin
          sh_r <= crc_tx;
          cnt_r <= crc_len;
        end
        if (after_data == S_IDLE) begin
          done_r <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // ahb-lite slave
  // --------------------------------------------------------------------
  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] a_idx = haddr[9:2];
  wire rd_status = addr_ok & ~hwrite & (a_idx == `RFE_IDX_IRQ_STATUS);
  wire [`RFE_IRQ_W-1:0] irq_set = {nodata_r, done_r};
  wire wr_cmd = ph_write_r & (ph_idx_r == `RFE_IDX_CMD);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_status_r & irq_mask_r);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_idx_r <= 8'h00;
    end else begin
      start_r <= wr_cmd & hwdata[`RFE_CMD_START] & (state_r == S_IDLE);
      if (hready) begin
        ph_write_r <= addr_ok & hwrite;
        ph_idx_r <= a_idx;
      end
    end
  end

  // --------------------------------------------------------------------
  // read data, loaded at the address phase
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (a_idx)
        `RFE_IDX_FRAME_SETUP: hrdata <= frame_setup_r;
        `RFE_IDX_CRC_SETUP: hrdata <= crc_setup_r;
        `RFE_IDX_NUM_BYTES: hrdata <= {{(32-CNT_W){1'b0}}, num_bytes_r};
        `RFE_IDX_IRQ_STATUS:
          hrdata <= {{(32-`RFE_IRQ_W){1'b0}}, irq_status_r};
        `RFE_IDX_IRQ_MASK:
          hrdata <= {{(32-`RFE_IRQ_W){1'b0}}, irq_mask_r};
        `RFE_IDX_STATE: hrdata <= {25'h0, state_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // interrupt status, read clears
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= {`RFE_IRQ_W{1'b0}};
    end else begin
      // a same-cycle event survives the clear
      irq_status_r <= (rd_status ? {`RFE_IRQ_W{1'b0}} : irq_status_r) |
        irq_set;
    end
  end

  // --------------------------------------------------------------------
  // configuration writes, data phase
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_setup_r <= `RFE_FS_RESET;
      crc_setup_r <= `RFE_CS_RESET;
      num_bytes_r <= {CNT_W{1'b0}};
      irq_mask_r <= {`RFE_IRQ_W{1'b0}};
    end else if (ph_write_r) begin
      case (ph_idx_r)
        `RFE_IDX_FRAME_SETUP:
          frame_setup_r <= hwdata & `RFE_FS_WMASK;
        `RFE_IDX_CRC_SETUP:
          crc_setup_r <= hwdata & `RFE_CS_WMASK;
        `RFE_IDX_NUM_BYTES: num_bytes_r <= hwdata[CNT_W-1:0];
        `RFE_IDX_IRQ_MASK: irq_mask_r <= hwdata[`RFE_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

endmodule

// File: test/rfe_sink_model.sv
// ------------------------------------------------------------------
// far-side element sink, prompt or stalling
// ------------------------------------------------------------------
module rfe_sink_model (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire slow, // stall every other cycle
  input wire out_valid, // element offered
  input wire out_is_sym, // element is a symbol
  input wire [1:0] out_sym, // symbol number
  input wire out_bit, // bit value
  output logic out_ready // element taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] got[$];
  logic tog_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_r <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      tog_r <= !tog_r;
      out_ready <= !slow || tog_r;
      if (out_valid && out_ready)
        got.push_back(out_is_sym ? {1'b1, out_sym} : {2'b00, out_bit});
    end
  end
endmodule

// File: test/rfe_tx_encoder_asserts.sv
module rfe_tx_encoder_asserts #(
  parameter ADDR_W = 12,
  parameter CNT_W = 16
) (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire hsel, // select
  input wire [ADDR_W-1:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire [2:0] hsize, // size
  input wire [31:0] hwdata, // write data
  input wire hready, // ready in
  input wire hreadyout, // ready out
  input wire hresp, // response
  input wire [31:0] hrdata, // read data
  input wire irq, // interrupt
  input wire [7:0] in_data, // byte
  input wire in_valid, // byte offered
  input wire in_ready, // byte taken
  input wire out_valid, // element offered
  input wire out_ready, // element taken
  input wire out_is_sym, // symbol flag
  input wire [1:0] out_sym, // symbol number
  input wire out_bit // bit value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen_data_r;
  // cleared at each start command
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      seen_data_r <= 1'b0;
    else if (hsel && htrans[1] && hwrite && haddr[9:2] == 8'h30)
      seen_data_r <= 1'b0;
    else if (out_valid && out_ready)
      seen_data_r <= !out_is_sym;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [7:0] idx);
    hsel && htrans[1] && hready && !hwrite && haddr[9:2] == idx;
  endsequence
  sequence byte_taken;
    in_valid && in_ready;
  endsequence
  sequence elem_stall;
    out_valid && !out_ready;
  endsequence
  unmapped_zero_a: assert property (rd_at(8'h00) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  frame_resv_a: assert property (rd_at(8'h18) |=> hrdata[31:14] == 18'h0)
    else $error("frame setup reserved bits set");
  crc_resv_a: assert property (rd_at(8'h19) |=> hrdata[15:7] == 9'h0)
    else $error("crc setup reserved bits set");
  elem_hold_a: assert property (elem_stall |=> out_valid &&
    $stable(out_is_sym) && (out_is_sym ? $stable(out_sym) : $stable(out_bit)))
    else $error("element changed before taken");
  byte_bit_a: assert property (byte_taken |=>
    out_valid && !out_is_sym && !in_ready)
    else $error("taken byte not followed by data bit");
  load_excl_a: assert property (in_ready |-> !out_valid)
    else $error("element offered while waiting for byte");
  stop_code_a: assert property (out_valid && out_is_sym && seen_data_r
    |-> out_sym != 2'd0)
    else $error("symbol zero after data");
  reset_quiet_a: assert property ($rose(hresetn) |-> !irq &&
    !out_valid && !in_ready && hrdata == 32'h0)
    else $error("outputs active after reset");
endmodule

bind rfe_tx_encoder rfe_tx_encoder_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W))
  chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .irq(irq), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_is_sym(out_is_sym),
  .out_sym(out_sym), .out_bit(out_bit));

// File: test/rfe_tx_encoder_bench.sv
`include "rfe_defines.vh"

module rfe_tx_encoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, in_valid, slow;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, rd;
  logic [7:0] in_data;
  logic [15:0] cur;
  wire hready, hresp, irq, in_ready, out_valid, out_ready, out_is_sym;
  wire out_bit;
  wire [31:0] hrdata;
  wire [1:0] out_sym;
  logic [2:0] exp_q[$];
  int num_errors, checked;
  // frame setup, crc setup, two data bytes
  logic [31:0] fs_t[10] = '{32'hD40, 32'h3EAB, 32'h7C0, 32'h400, 32'h400,
    32'h400, 32'h400, 32'h400, 32'h140, 32'h1C00};
  logic [31:0] cs_t[10] = '{32'h1, 32'hB, 32'h15, 32'h59, 32'h21, 32'h29,
    32'h12340039, 32'h31, 32'h1, 32'h0};
  logic [15:0] d_t[10] = '{16'h3CA5, 16'hC35A, 16'h0F81, 16'h1234, 16'h8001,
    16'h7EE7, 16'hFF00, 16'h00FF, 16'h5555, 16'h9669};

  rfe_tx_encoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_is_sym(out_is_sym), .out_sym(out_sym), .out_bit(out_bit));
  rfe_sink_model sink (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .out_valid(out_valid), .out_is_sym(out_is_sym), .out_sym(out_sym),
    .out_bit(out_bit), .out_ready(out_ready));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // second byte offered once the first is taken
  always @(posedge hclk) begin
    if (in_valid && in_ready) in_data <= cur[15:8];
  end

  // ------------------------------------------------------------------
  // bus, compare and model tasks
  // ------------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {2'b00, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_q();
    logic bad;
    bad = (sink.got.size() != exp_q.size());
    for (int k = 0; k < exp_q.size() && !bad; k++)
      bad = (sink.got[k] !== exp_q[k]);
    checked++;
    if (bad) begin
      num_errors++;
      $display("MISMATCH %0t element stream differs", $time);
    end
  endtask
  task automatic gen(input logic [31:0] fs, input logic [31:0] cs);
    logic [15:0] c, pv;
    int lo, hi;
    logic p, bt, fb;
    exp_q.delete();
    if (fs[7:6] != 2'd0) exp_q.push_back({1'b1, fs[7:6] - 2'd1});
    case (cs[5:3])
      3'd1: pv = 16'h6363;
      3'd2: pv = 16'hA671;
      3'd3: pv = 16'hFFFF;
      3'd4: pv = 16'h0012;
      3'd5: pv = 16'hE012;
      3'd7: pv = cs[31:16];
      default: pv = 16'h0000;
    endcase
    c = cs[2] ? {11'h0, pv[4:0]} : pv;
    for (int k = 0; k < 2 && fs[10]; k++) begin
      lo = (k == 0 && fs[2:0] != 0) ? 8 - fs[2:0] : 0;
      hi = (k == 1 && fs[5:3] != 0) ? fs[5:3] : 8;
      p = fs[12];
      for (int b = lo; b < hi; b++) begin
        bt = cur[8 * k + b];
        p ^= bt;
        exp_q.push_back({2'b00, bt});
        if (!(cs[6] && k == 0)) begin
          fb = c[0] ^ bt;
          c = c >> 1;
          if (fb) c ^= cs[2] ? 16'h0012 : 16'h8408;
        end
      end
      if (fs[11]) exp_q.push_back({2'b00, p ^ (k == 1 && fs[13])});
    end
    for (int b = 0; b < (cs[2] ? 5 : 16) && fs[10] && cs[0]; b++)
      exp_q.push_back({2'b00, c[b] ^ cs[1]});
    if (fs[9:8] != 2'd0) exp_q.push_back({1'b1, fs[9:8]});
  endtask
  task automatic start_frame(input logic [31:0] fs, input logic [31:0] n);
    bus(1'b1, `RFE_IDX_FRAME_SETUP, fs, rd);
    bus(1'b1, `RFE_IDX_NUM_BYTES, n, rd);
    sink.got.delete();
    in_data <= cur[7:0];
    bus(1'b1, `RFE_IDX_CMD, 32'h1, rd);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    {hresetn, hsel, hwrite, in_valid, slow} = 5'b0;
    {haddr, htrans, hwdata, in_data, cur} = '0;
    hsize = 3'b010;
    num_errors = 0;
    checked = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    in_valid <= 1'b1;
    // ----------------------------------------------------------------
    // frame table
    // ----------------------------------------------------------------
    for (int i = 0; i < 10; i++) begin
      slow <= i[0];
      bus(1'b1, `RFE_IDX_CRC_SETUP, cs_t[i], rd);
      cur = d_t[i];
      gen(fs_t[i], cs_t[i]);
      start_frame(fs_t[i], 32'h2);
      rd = 32'h0;
      for (int n = 0; n < 400 && !rd[0]; n++)
        bus(1'b0, `RFE_IDX_IRQ_STATUS, 32'h0, rd);
      chk_q();
    end
    // ----------------------------------------------------------------
    // no-data error, interrupt raised, cleared and masked
    // ----------------------------------------------------------------
    bus(1'b1, `RFE_IDX_IRQ_MASK, 32'h2, rd);
    start_frame(32'h400, 32'h0);
    repeat (4) @(posedge hclk);
    #1 chk32({31'h0, irq}, 32'h1);
    bus(1'b0, `RFE_IDX_IRQ_STATUS, 32'h0, rd);
    chk32(rd & 32'h2, 32'h2);
    #1 chk32({31'h0, irq}, 32'h0);
    chk32(sink.got.size(), 32'h0);
    bus(1'b1, `RFE_IDX_IRQ_MASK, 32'h0, rd);
    start_frame(32'h400, 32'h0);
    repeat (4) @(posedge hclk);
    #1 chk32({31'h0, irq}, 32'h0);
    bus(1'b0, `RFE_IDX_IRQ_STATUS, 32'h0, rd);
    chk32(rd & 32'h2, 32'h2);
    // ----------------------------------------------------------------
    // reset values, reserved bits, unmapped index
    // ----------------------------------------------------------------
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `RFE_IDX_FRAME_SETUP, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b0, `RFE_IDX_CRC_SETUP, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b1, `RFE_IDX_FRAME_SETUP, 32'hFFFFFFFF, rd);
    bus(1'b0, `RFE_IDX_FRAME_SETUP, 32'h0, rd);
    chk32(rd, 32'h00003FFF);
    bus(1'b1, `RFE_IDX_CRC_SETUP, 32'hFFFFFFFF, rd);
    bus(1'b0, `RFE_IDX_CRC_SETUP, 32'h0, rd);
    chk32(rd, 32'hFFFF007F);
    bus(1'b1, 8'h00, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk32(rd, 32'h0);
    chk32({31'h0, hresp}, 32'h0);
    bus(1'b0, `RFE_IDX_STATE, 32'h0, rd);
    chk32(rd, 32'h1);
    bus(1'b0, `RFE_IDX_IRQ_MASK, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b1, `RFE_IDX_NUM_BYTES, 32'hFFFFFFFF, rd);
    bus(1'b0, `RFE_IDX_NUM_BYTES, 32'h0, rd);
    chk32(rd, 32'h0000FFFF);
    report_and_stop();
  end
endmodule
